// *** bench/rtseq_partner.sv ***
// Purpose: Far side: supply detectors, clear pin, oscillators
// Assumes: Bench sets the levels at clock edges
// Notes: Ticks run free, as real oscillators do
`timescale 1ns/10ps
`default_nettype none
module rtseq_partner (
    // Bench commands
    input wire logic por_cmd_i,
    input wire logic bor_cmd_i,
    input wire logic clr_cmd_i,
    // Pins
    output logic power_on_o,
    output logic brown_out_o,
    output logic external_clear_n_o,
    output logic rc_tick_o,
    output logic osc_tick_o
);
    // Odd half periods over two core cycles: unrelated, yet never lost in the pin filter
    initial rc_tick_o = 1'b0;
    initial osc_tick_o = 1'b0;
    always #97 rc_tick_o = ~rc_tick_o;
    always #101 osc_tick_o = ~osc_tick_o;
    assign power_on_o = por_cmd_i;
    assign brown_out_o = bor_cmd_i;
    assign external_clear_n_o = clr_cmd_i;
endmodule
`default_nettype wire

// *** bench/test_reset_timeout_sequencer.sv ***
// Purpose: Self-checking bench for the reset time-out sequencer
// Assumes: Delays shortened to 5 and 4 ticks
// Notes: Random pc and wake sources from an LFSR seeded at 59
`timescale 1ns/10ps
`default_nettype none
module test_reset_timeout_sequencer;
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1, pc_c = 1'b0, bc = 1'b0, cc = 1'b1, wdt = 1'b0;
    logic wk = 1'b0, slp = 1'b0, global_interrupt_enable = 1'b0, xt = 1'b1, pden = 1'b0, awv = 1'b0, wv = 1'b0;
    logic bry = 1'b0, arv = 1'b0, rry = 1'b0, pon, bon, cln, rct, osct, rst, ld, irq;
    logic awr, wr, bv, arr, rv, tof, pdf, bde = 1'b1, hs = 1'b0;
    logic [12:0] pc = 13'h0000, pcv, pcs;
    logic [7:0] src = 8'h00, pdir, wfl, lf = 8'h3B;
    logic [31:0] wd = 32'h0, rd, d;
    logic [3:0] aa = 4'h0, ra = 4'h0;
    logic [1:0] rr, r, bres, br;
    int n_mismatch = 0, tests_run = 0, n_ld = 0, n, ld0 = 0;
    always #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (ld === 1'b1) begin
            pcs <= pcv;
            n_ld <= n_ld + 1;
        end
    end
    rtseq_partner far (.por_cmd_i(pc_c), .bor_cmd_i(bc), .clr_cmd_i(cc), .power_on_o(pon),
        .brown_out_o(bon), .external_clear_n_o(cln), .rc_tick_o(rct), .osc_tick_o(osct));
    rtseq_top #(.PWRUP_CYCLES(5), .OSC_CYCLES(4)) uut (.core_clk_i, .sys_rst_i,
        .external_clear_n_i(cln), .power_on_i(pon), .brown_out_i(bon), .wdt_timeout_i(wdt),
        .wake_irq_i(wk), .wake_src_i(src), .brown_out_detect_enable_i(bde),
        .power_up_delay_enable_n_i(pden), .crystal_osc_mode_i(xt),
        .high_speed_osc_mode_i(hs), .low_power_osc_mode_i(1'b0),
        .global_interrupt_enable_i(global_interrupt_enable), .sleep_i(slp), .pc_i(pc), .rc_tick_i(rct),
        .osc_tick_i(osct), .core_reset_o(rst), .pc_load_o(ld), .pc_value_o(pcv),
        .port_dir_o(pdir), .wake_flags_o(wfl), .time_out_flag_o(tof), .power_down_flag_o(pdf),
        .irq_o(irq), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic give_verdict(input bit hung);
        if (hung) n_mismatch++;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", w, e, s);
        end
    endtask
    // Ready is sampled mid-cycle, released by the next rising edge
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        logic ka, kw, kb;
        @(posedge core_clk_i);
        {aa, wd, awv, wv, bry} <= {a, v, 3'b111};
        kb = 1'b0;
        for (int k = 0; k < 50 && !kb; k++) begin
            @(negedge core_clk_i);
            {ka, kw, kb, br} = {awv & awr, wv & wr, bv, bres};
            @(posedge core_clk_i);
            {awv, wv, bry} <= {awv & ~ka, wv & ~kw, ~kb};
        end
        if (!kb) give_verdict(1);
        repeat (2) @(posedge core_clk_i);
    endtask
    task automatic axr(input logic [3:0] a);
        logic ka, kb;
        @(posedge core_clk_i);
        {ra, arv, rry} <= {a, 2'b11};
        kb = 1'b0;
        for (int k = 0; k < 50 && !kb; k++) begin
            @(negedge core_clk_i);
            {ka, kb, d, r} = {arv & arr, rv, rd, rr};
            @(posedge core_clk_i);
            {arv, rry} <= {arv & ~ka, ~kb};
        end
        if (!kb) give_verdict(1);
    endtask
    // Load count taken before the event: a quick restart may come while it is held
    task automatic ev(input logic [3:0] m);
        ld0 = n_ld;
        @(posedge core_clk_i);
        {wk, wdt, bc, pc_c} <= m;
        repeat (8) @(posedge core_clk_i);
        {wk, wdt, bc, pc_c} <= 4'h0;
    endtask
    task automatic waitld;
        for (n = 0; n < 300 && n_ld == ld0; n++) @(negedge core_clk_i);
        if (n == 300) give_verdict(1);
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        axr(4'h0);
        chk(d, 32'h1, "power_control_status reset");
        ev(4'h1);
        waitld();
        chk(n > 25, 1, "por delay");
        chk({pcs, pdir}, {13'h0, 8'hFF}, "pc and dir");
        axr(4'h0);
        chk(d, 32'h1, "power_control_status por");
        axr(4'h4);
        chk(d, 32'h7, "stat por");
        chk({pdf, tof}, 2'b11, "flags por");
        axw(4'hC, 32'h1F);
        chk(br, 2'h0, "write okay");
        chk(irq, 1, "irq on");
        axw(4'hC, 32'h0);
        chk(irq, 0, "irq masked");
        axr(4'h8);
        chk(d[0], 1, "irq por");
        axw(4'hC, 32'h1F);
        chk(irq, 0, "irq cleared");
        axw(4'h0, 32'h3);
        ev(4'h2);
        waitld();
        chk(n > 25, 1, "bor delay");
        axr(4'h0);
        chk(d, 32'h2, "power_control_status bor");
        axw(4'h0, 32'h3);
        ev(4'h4);
        waitld();
        axr(4'h0);
        chk(d, 32'h3, "power_control_status wdt");
        axr(4'h4);
        chk(d[1:0], 2'b10, "stat wdt");
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            {pc, src, global_interrupt_enable, slp} <= {lf[4:0], lf, lf, i == 0, 1'b1};
            ev(i < 2 ? 4'h8 : 4'h4);
            waitld();
            slp <= 1'b0;
            chk(pcs, i == 0 ? 13'h4 : pc + 13'h1, "wake pc");
            axr(4'h4);
            chk(d[1:0], i < 2 ? 2'b01 : 2'b00, "wake stat");
            chk({pdf, tof}, i < 2 ? 2'b01 : 2'b00, "wake flags");
            if (i < 2) chk(wfl & lf, lf, "wake src");
        end
        {xt, hs} <= 2'b01;
        cc <= 1'b0;
        ev(4'h1);
        repeat (120) @(posedge core_clk_i);
        chk(rst, 1, "held by pin");
        cc <= 1'b1;
        waitld();
        chk(n < 10, 1, "pin release");
        {xt, hs, pden} <= 3'b001;
        ev(4'h1);
        waitld();
        chk(n < 12, 1, "rc no delay");
        axr(4'h2);
        chk(r, 2'h2, "unmapped");
        axw(4'h2, 32'h0);
        chk(br, 2'h2, "unmapped write");
        give_verdict(0);
    end
endmodule
`default_nettype wire

// *** rtl/rtseq_pkg.sv ***
// Purpose: Shared constants for the reset time-out sequencer
// Assumes: 25 MHz core clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package rtseq_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int PWRUP_MS = 72;
    localparam int PWRUP_CYC = (PWRUP_MS * (CLK_HZ / 1000));
    localparam int OSC_CYC = 1024;
    localparam int OSC_W = 11;
    localparam int PWR_W = 21;
    // Register byte offsets
    localparam logic [3:0] REG_POWER_CONTROL_STATUS = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ = 4'h8;
    localparam logic [3:0] REG_MASK = 4'hC;
    // Field positions
    localparam int BIT_BOR = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_TO = 0;
    localparam int BIT_PD = 1;
    localparam int BIT_RUN = 2;
    // Interrupt event positions
    localparam int EV_POR = 0;
    localparam int EV_BOR = 1;
    localparam int EV_WDT = 2;
    localparam int EV_EXTERNAL_CLEAR_N = 3;
    localparam int EV_WAKE = 4;
    localparam int EV_W = 5;
    // Program counter start points
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_VECTOR = 13'h0004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] TRIS_INPUT = 8'hFF;
endpackage

// *** rtl/rtseq_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to core_clk_i
// Notes: Output changes only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module rtseq_sync #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Data
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } rtseq_sync_t;
    rtseq_sync_t st_ff;
    rtseq_sync_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.out = st_ff.s3;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= {INIT, INIT, INIT, INIT};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.out;
endmodule
`default_nettype wire

// *** rtl/rtseq_tmr.sv ***
// Purpose: Down counter that holds done once its count expires
// Assumes: tick_i marks one period of the counted clock
// Notes: start_i reloads and restarts, overriding a running count
`timescale 1ns/10ps
`default_nettype none
module rtseq_tmr #(
    parameter int W = 11
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [W-1:0] load_i,
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
    } rtseq_tmr_t;
    rtseq_tmr_t st_ff;
    rtseq_tmr_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (start_i) begin
            nxt_st.cnt = load_i;
            nxt_st.run = 1'b1;
        end else if (st_ff.run && tick_i) begin
            if (st_ff.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
                nxt_st.run = 1'b0;
                nxt_st.cnt = '0;
            end else begin
                nxt_st.cnt = st_ff.cnt - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = ~st_ff.run & ~start_i;
endmodule
`default_nettype wire

// *** rtl/rtseq_top.sv ***
// Purpose: Reset time-out sequencing and reset-cause reporting
// Assumes: Detector and pin inputs asynchronous; osc and RC ticks are async levels
// Notes: Core is held in reset by core_reset_o until all delays complete
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rtseq_top #(
    parameter int PWRUP_CYCLES = rtseq_pkg::PWRUP_CYC,
    parameter int OSC_CYCLES = rtseq_pkg::OSC_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Reset sources
    input wire logic external_clear_n_i,
    input wire logic power_on_i,
    input wire logic brown_out_i,
    input wire logic wdt_timeout_i,
    input wire logic wake_irq_i,
    input wire logic [7:0] wake_src_i,
    // Configuration and core state
    input wire logic brown_out_detect_enable_i,
    input wire logic power_up_delay_enable_n_i,
    input wire logic crystal_osc_mode_i,
    input wire logic high_speed_osc_mode_i,
    input wire logic low_power_osc_mode_i,
    input wire logic global_interrupt_enable_i,
    input wire logic sleep_i,
    input wire logic [12:0] pc_i,
    // Timebases
    input wire logic rc_tick_i,
    input wire logic osc_tick_i,
    // Core control
    output logic core_reset_o,
    output logic pc_load_o,
    output logic [12:0] pc_value_o,
    output logic [7:0] port_dir_o,
    output logic [7:0] wake_flags_o,
    output logic time_out_flag_o,
    output logic power_down_flag_o,
    output logic irq_o,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [3:0] {
        SQ_HOLD = 4'h1,
        SQ_PWRUP = 4'h2,
        SQ_OSC = 4'h4,
        SQ_RUN = 4'h8
    } rtseq_state_t;

    typedef struct packed {
        rtseq_state_t sq;
        logic por_prev;
        logic bor_prev;
        logic external_clear_n_prev;
        logic wdt_prev;
        logic wake_prev;
        logic rc_prev;
        logic osc_prev;
        logic por_stat_n;
        logic bor_stat_n;
        logic to_f;
        logic pd_f;
        logic [rtseq_pkg::EV_W-1:0] irq_st;
        logic [rtseq_pkg::EV_W-1:0] irq_msk;
        logic core_rst;
        logic pc_load;
        logic [12:0] pc_val;
        logic [7:0] port_dir;
        logic [7:0] wflags;
        logic irq;
        logic [3:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rtseq_regs_t;

    rtseq_regs_t st_ff;
    rtseq_regs_t nxt_st;

    logic por_s, bor_s, external_clear_n_n_s, wdt_s, wake_s, rc_s, osc_s;
    logic pwr_start, osc_start, pwr_done, osc_done;
    logic rc_tick, osc_tick, crystal;
    logic por_rise, bor_rise, wdt_rise, wake_rise, external_clear_n_fall;

    // One synchroniser per asynchronous source
    localparam int NS = 7;
    logic [NS-1:0] as_in, as_out;
    assign as_in = {osc_tick_i, rc_tick_i, wake_irq_i, wdt_timeout_i,
                    external_clear_n_i, brown_out_i, power_on_i};
    assign {osc_s, rc_s, wake_s, wdt_s, external_clear_n_n_s, bor_s, por_s} = as_out;
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            rtseq_sync #(.INIT(1'b0)) u_sync (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .async_i(as_in[gi]),
                .sync_o(as_out[gi])
            );
        end
    endgenerate

    assign rc_tick = rc_s & ~st_ff.rc_prev;
    assign osc_tick = osc_s & ~st_ff.osc_prev;
    assign por_rise = por_s & ~st_ff.por_prev;
    assign bor_rise = bor_s & ~st_ff.bor_prev & brown_out_detect_enable_i;
    assign wdt_rise = wdt_s & ~st_ff.wdt_prev;
    assign wake_rise = wake_s & ~st_ff.wake_prev;
    assign external_clear_n_fall = ~external_clear_n_n_s & st_ff.external_clear_n_prev;
    assign crystal = crystal_osc_mode_i | high_speed_osc_mode_i | low_power_osc_mode_i;

    // Power-up delay on RC ticks, oscillator count on osc ticks
    rtseq_tmr #(.W(rtseq_pkg::PWR_W)) u_pwr (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(pwr_start),
        .tick_i(rc_tick),
        .load_i(rtseq_pkg::PWR_W'(PWRUP_CYCLES)),
        .done_o(pwr_done)
    );
    rtseq_tmr #(.W(rtseq_pkg::OSC_W)) u_osc (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(osc_start),
        .tick_i(osc_tick),
        .load_i(rtseq_pkg::OSC_W'(OSC_CYCLES)),
        .done_o(osc_done)
    );

    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] wv;
    logic bor_hold;
    logic wake_go;
    logic [12:0] wake_pc;

    always_comb begin
        nxt_st = st_ff;
        pwr_start = 1'b0;
        osc_start = 1'b0;
        wv = '0;
        nxt_st.por_prev = por_s;
        nxt_st.bor_prev = bor_s;
        nxt_st.external_clear_n_prev = external_clear_n_n_s;
        nxt_st.wdt_prev = wdt_s;
        nxt_st.wake_prev = wake_s;
        nxt_st.rc_prev = rc_s;
        nxt_st.osc_prev = osc_s;
        nxt_st.pc_load = 1'b0;
        bor_hold = bor_s & brown_out_detect_enable_i;
        wake_go = 1'b0;
        wake_pc = rtseq_pkg::PC_RESET;

        // Sequencer
        case (st_ff.sq)
            SQ_HOLD: begin
                nxt_st.core_rst = 1'b1;
                // Leave hold once power-on pulse and brown-out have ended
                if (!por_s && !bor_hold) begin
                    if (!power_up_delay_enable_n_i) begin
                        pwr_start = 1'b1;
                        nxt_st.sq = SQ_PWRUP;
                    end else if (crystal && st_ff.to_f && st_ff.pd_f && !st_ff.bor_stat_n) begin
                        osc_start = 1'b1; // Brown-out without delay still waits osc
                        nxt_st.sq = SQ_OSC;
                    end else if (crystal && !st_ff.por_stat_n) begin
                        osc_start = 1'b1;
                        nxt_st.sq = SQ_OSC;
                    end else begin
                        nxt_st.sq = SQ_RUN; // RC with delay disabled: no time-out
                    end
                end
            end
            SQ_PWRUP: begin
                nxt_st.core_rst = 1'b1;
                if (pwr_done) begin
                    if (crystal) begin
                        osc_start = 1'b1; // Oscillator count follows the delay
                        nxt_st.sq = SQ_OSC;
                    end else begin
                        nxt_st.sq = SQ_RUN;
                    end
                end
            end
            SQ_OSC: begin
                if (osc_done) begin
                    nxt_st.sq = SQ_RUN;
                end
            end
            SQ_RUN: begin
                // Core runs only while the clear pin is high
                if (external_clear_n_n_s && st_ff.core_rst) begin
                    nxt_st.core_rst = 1'b0;
                    nxt_st.pc_load = 1'b1;
                    nxt_st.pc_val = rtseq_pkg::PC_RESET;
                end else if (!external_clear_n_n_s) begin
                    nxt_st.core_rst = 1'b1;
                end
            end
            default: begin
                nxt_st.sq = SQ_HOLD;
            end
        endcase

        // Wake resumes once the oscillator count ends; address latched at wake
        if (st_ff.sq == SQ_OSC && osc_done && !st_ff.core_rst) begin
            nxt_st.pc_load = 1'b1;
        end

        // Reset cause recording
        if (external_clear_n_fall) begin
            nxt_st.core_rst = 1'b1;
            nxt_st.port_dir = rtseq_pkg::TRIS_INPUT;
            nxt_st.irq_st[rtseq_pkg::EV_EXTERNAL_CLEAR_N] = 1'b1;
            if (sleep_i) begin
                nxt_st.to_f = 1'b1;
                nxt_st.pd_f = 1'b0;
            end
        end
        if (wdt_rise) begin
            nxt_st.irq_st[rtseq_pkg::EV_WDT] = 1'b1;
            if (sleep_i) begin
                nxt_st.to_f = 1'b0; // Watchdog wake clears both
                nxt_st.pd_f = 1'b0;
                wake_go = 1'b1;
                wake_pc = pc_i + 13'h0001;
            end else begin
                nxt_st.to_f = 1'b0;
                nxt_st.pd_f = 1'b1;
                nxt_st.core_rst = 1'b1;
                nxt_st.port_dir = rtseq_pkg::TRIS_INPUT;
                nxt_st.sq = SQ_RUN;
            end
        end
        if (wake_rise && sleep_i) begin
            nxt_st.irq_st[rtseq_pkg::EV_WAKE] = 1'b1;
            nxt_st.to_f = 1'b1;
            nxt_st.pd_f = 1'b0;
            nxt_st.wflags = st_ff.wflags | wake_src_i; // Source shown in flags
            wake_go = 1'b1;
            wake_pc = global_interrupt_enable_i ? rtseq_pkg::PC_VECTOR
                                                : pc_i + 13'h0001;
        end
        // Crystal wake waits the oscillator count only; resets below still win
        if (wake_go) begin
            nxt_st.pc_val = wake_pc;
            if (crystal) begin
                osc_start = 1'b1;
                nxt_st.sq = SQ_OSC;
            end else begin
                nxt_st.pc_load = 1'b1;
            end
        end
        if (bor_rise) begin
            nxt_st.bor_stat_n = 1'b0;
            nxt_st.to_f = 1'b1;
            nxt_st.pd_f = 1'b1;
            nxt_st.core_rst = 1'b1;
            nxt_st.port_dir = rtseq_pkg::TRIS_INPUT;
            nxt_st.irq_st[rtseq_pkg::EV_BOR] = 1'b1;
        end
        // Brown-out while delay runs restarts the whole hold
        if (bor_hold) begin
            nxt_st.sq = SQ_HOLD;
            nxt_st.core_rst = 1'b1;
        end
        if (por_rise) begin
            nxt_st.por_stat_n = 1'b0;
            nxt_st.to_f = 1'b1;
            nxt_st.pd_f = 1'b1;
            nxt_st.bor_stat_n = brown_out_detect_enable_i ? 1'b1 : st_ff.bor_stat_n;
            nxt_st.core_rst = 1'b1;
            nxt_st.port_dir = rtseq_pkg::TRIS_INPUT;
            nxt_st.wflags = '0;
            nxt_st.sq = SQ_HOLD;
            nxt_st.irq_st[rtseq_pkg::EV_POR] = 1'b1;
        end

        // AXI4-Lite write
        if (s_axi_awvalid && !st_ff.aw_have && !st_ff.bvalid) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_have && !st_ff.bvalid) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.aw_have && st_ff.w_have) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = rtseq_pkg::RESP_OKAY;
            case (st_ff.awaddr)
                rtseq_pkg::REG_POWER_CONTROL_STATUS: begin
                    // Software sets the flags; hardware clear above wins
                    wv = wr_merge({30'h0, st_ff.por_stat_n, st_ff.bor_stat_n},
                                  st_ff.wdata, st_ff.wstrb);
                    if (!por_rise) begin
                        nxt_st.por_stat_n = wv[rtseq_pkg::BIT_POR];
                    end
                    if (!bor_rise && !por_rise) begin
                        nxt_st.bor_stat_n = wv[rtseq_pkg::BIT_BOR];
                    end
                end
                rtseq_pkg::REG_MASK: begin
                    wv = wr_merge({27'h0, st_ff.irq_msk}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.irq_msk = wv[rtseq_pkg::EV_W-1:0];
                end
                rtseq_pkg::REG_STAT, rtseq_pkg::REG_IRQ: begin
                end
                default: begin
                    nxt_st.bresp = rtseq_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // AXI4-Lite read; interrupt register read clears, but a new event in that cycle wins
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = rtseq_pkg::RESP_OKAY;
            nxt_st.rdata = '0;
            case (s_axi_araddr)
                rtseq_pkg::REG_POWER_CONTROL_STATUS: begin
                    nxt_st.rdata[rtseq_pkg::BIT_POR] = st_ff.por_stat_n;
                    nxt_st.rdata[rtseq_pkg::BIT_BOR] = st_ff.bor_stat_n;
                end
                rtseq_pkg::REG_STAT: begin
                    nxt_st.rdata[rtseq_pkg::BIT_TO] = st_ff.to_f;
                    nxt_st.rdata[rtseq_pkg::BIT_PD] = st_ff.pd_f;
                    nxt_st.rdata[rtseq_pkg::BIT_RUN] = ~st_ff.core_rst;
                end
                rtseq_pkg::REG_IRQ: begin
                    nxt_st.rdata[rtseq_pkg::EV_W-1:0] = st_ff.irq_st;
                    nxt_st.irq_st = nxt_st.irq_st & ~st_ff.irq_st;
                    nxt_st.irq_st = nxt_st.irq_st |
                        {wake_rise & sleep_i, external_clear_n_fall, wdt_rise, bor_rise, por_rise};
                end
                rtseq_pkg::REG_MASK: begin
                    nxt_st.rdata[rtseq_pkg::EV_W-1:0] = st_ff.irq_msk;
                end
                default: begin
                    nxt_st.rresp = rtseq_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_msk);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
            st_ff.sq <= SQ_HOLD;
            st_ff.core_rst <= 1'b1;
            st_ff.external_clear_n_prev <= 1'b0;
            st_ff.por_stat_n <= 1'b0;
            st_ff.bor_stat_n <= 1'b1;
            st_ff.to_f <= 1'b1;
            st_ff.pd_f <= 1'b1;
            st_ff.port_dir <= rtseq_pkg::TRIS_INPUT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign core_reset_o = st_ff.core_rst;
    assign pc_load_o = st_ff.pc_load;
    assign pc_value_o = st_ff.pc_val;
    assign port_dir_o = st_ff.port_dir;
    assign wake_flags_o = st_ff.wflags;
    assign time_out_flag_o = st_ff.to_f;
    assign power_down_flag_o = st_ff.pd_f;
    assign irq_o = st_ff.irq;
    assign s_axi_awready = ~st_ff.aw_have & ~st_ff.bvalid;
    assign s_axi_wready = ~st_ff.w_have & ~st_ff.bvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = ~st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    property p_por_flags;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        por_rise |=> (!st_ff.por_stat_n && st_ff.to_f && st_ff.pd_f && core_reset_o);
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");
    property p_wdt_run;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (wdt_rise && !sleep_i && !por_rise && !bor_rise) |=> (!st_ff.to_f && st_ff.pd_f);
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset flags wrong");
    property p_dir;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (por_rise || bor_rise) |=> (port_dir_o == rtseq_pkg::TRIS_INPUT);
    endproperty
    a_dir: assert property (p_dir) else $error("ports not inputs after reset");
    property p_rst_hold;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (st_ff.sq == SQ_PWRUP) |-> core_reset_o;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("core released during delay");
    property p_bor_flags;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (bor_rise && !por_rise) |=>
            (!st_ff.bor_stat_n && st_ff.to_f && st_ff.pd_f && core_reset_o);
    endproperty
    a_bor_flags: assert property (p_bor_flags) else $error("brown-out flags wrong");
    sequence s_pwr_end;
        (st_ff.sq == SQ_PWRUP) && pwr_done && crystal && !bor_hold && !por_rise && !wdt_rise;
    endsequence
    property p_osc_after;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_pwr_end |=> ((st_ff.sq == SQ_OSC) && core_reset_o);
    endproperty
    a_osc_after: assert property (p_osc_after) else $error("oscillator count not started");
endmodule
`default_nettype wire
